// ===== alms_regs.svh
// register map, field positions, reset values and frame counts of the
// alarm mask and status block.
// assumes a 13-bit serial-port address and byte-wide registers.
`ifndef ALMS_REGS_SVH
`define ALMS_REGS_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define ALMS_ADDR_PLL1_MASK   13'h0070
`define ALMS_ADDR_GEN_MASK    13'h0071
`define ALMS_ADDR_ID_LOW      13'h0078
`define ALMS_ADDR_ID_MID      13'h0079
`define ALMS_ADDR_ID_HIGH     13'h007a
`define ALMS_ADDR_ALARM_RB    13'h007b
`define ALMS_ADDR_PLL1_STAT   13'h007c

// ****************************************************************
// field positions
// ****************************************************************
`define ALMS_P1_NEAR_LOCK     7
`define ALMS_P1_ACQUIRE       6
`define ALMS_P1_LOCKED        5
`define ALMS_P1_HOLDOVER      4
`define ALMS_P1_LOS_HI        3
`define ALMS_GEN_SYNC_REQ     4
`define ALMS_GEN_BOTH_LOCK    3
`define ALMS_GEN_PHASE        2
`define ALMS_GEN_SYSREF_SYNC  1
`define ALMS_GEN_PLL2_LOCK    0
`define ALMS_GEN_USED_MASK    8'h1f
`define ALMS_RB_ALARM         0

// ****************************************************************
// reset values
// ****************************************************************
`define ALMS_RST_PLL1_MASK    8'h00
`define ALMS_RST_GEN_MASK     8'h00

// ****************************************************************
// serial frame counts
// ****************************************************************
`define ALMS_INSTR_LAST       5'h0f
`define ALMS_BYTE_LAST        5'h07
// near lock when counter reaches limit / 16
`define ALMS_NEAR_SHIFT       4

`endif

// ===== alms_pkg.sv
// types of the alarm mask and status block.
// assumes alms_regs.svh is included by the design files that need it.
package alms_pkg;

  typedef logic [7:0]  alms_byte_t;
  typedef logic [12:0] alms_addr_t;

  typedef enum logic [1:0] {
    ALMS_IDLE,
    ALMS_INSTR,
    ALMS_WDATA,
    ALMS_RDATA
  } alms_phase_e;

  typedef struct packed {
    logic        sclk_q;
    alms_phase_e phase;
    logic [4:0]  bit_cnt;
    logic [15:0] shift;
    alms_addr_t  addr;
    alms_byte_t  rd_sh;
    logic        sdo;
    logic        sdo_en;
    alms_byte_t  pll1_mask;
    alms_byte_t  gen_mask;
    logic        alarm;
  } alms_top_s;

  typedef struct packed {
    logic near_lock;
    logic sync_req;
    logic both_lock;
    logic phase_ok;
    logic synced;
    logic pll2_lock;
  } alms_cond_s;

endpackage

// ===== alms_cond.sv
// condition derivation: near lock, sync request, sysref sync history.
// assumes all status inputs are synchronous to core_clk.
`timescale 1ns/1ps
`include "alms_regs.svh"

module alms_cond
  import alms_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // pll status
  input  wire logic [15:0] pll1_lock_cnt,
  input  wire logic [15:0] pll1_lock_limit,
  input  wire logic        pll1_locked,
  input  wire logic        pll2_locked,
  input  wire logic        pll2_disabled,
  input  wire logic        dividers_synced,
  // sync events
  input  wire logic        ext_sync_pulse,
  input  wire logic        spi_sync_req,
  input  wire logic        sysref_phase_stable,
  // conditions
  output logic             near_lock,
  output logic             sync_req,
  output logic             both_lock,
  output logic             phase_ok,
  output logic             sysref_unsynced,
  output logic             pll2_lock
);

  alms_cond_s s_ff;
  alms_cond_s nxt_s;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.near_lock = pll1_lock_cnt >=
                      (pll1_lock_limit >> `ALMS_NEAR_SHIFT);
    nxt_s.sync_req  = (pll2_locked | pll2_disabled) &
                      ~dividers_synced;
    nxt_s.both_lock = pll1_locked & pll2_locked;
    nxt_s.phase_ok  = sysref_phase_stable;
    // history only ever sets until reset
    if (ext_sync_pulse | spi_sync_req) begin
      nxt_s.synced  = 1'b1;
    end
    nxt_s.pll2_lock = pll2_locked;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign near_lock       = s_ff.near_lock;
  assign sync_req        = s_ff.sync_req;
  assign both_lock       = s_ff.both_lock;
  assign phase_ok        = s_ff.phase_ok;
  assign sysref_unsynced = ~s_ff.synced;
  assign pll2_lock       = s_ff.pll2_lock;

endmodule

// ===== alms_top.sv
// alarm mask and status block with its serial-port register access.
// assumes sclk, sen_n and sdio are synchronous to core_clk and that sclk
// is slow enough for each level to last at least one core_clk cycle.
`timescale 1ns/1ps
`include "alms_regs.svh"

module alms_top
  import alms_pkg::*;
#(
  // arbitrary identifier value
  parameter logic [23:0] PRODUCT_ID = 24'h5a3c71
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // serial port
  input  wire logic        spi_sclk,
  input  wire logic        spi_sen_n,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  // pll1 status
  input  wire logic [15:0] pll1_lock_cnt,
  input  wire logic [15:0] pll1_lock_limit,
  input  wire logic        pll1_acquiring,
  input  wire logic        pll1_locked,
  input  wire logic        pll1_holdover,
  input  wire logic [3:0]  input_signal_lost,
  // pll2 and sync status
  input  wire logic        pll2_locked,
  input  wire logic        pll2_disabled,
  input  wire logic        dividers_synced,
  input  wire logic        ext_sync_pulse,
  input  wire logic        spi_sync_req,
  input  wire logic        sysref_phase_stable,
  // alarm
  output logic             alarm
);

  alms_top_s  s_ff;
  alms_top_s  nxt_s;
  alms_byte_t pll1_status;
  alms_byte_t gen_status;
  logic       alarm_c;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [15:0] instr;
  alms_byte_t  wbyte;
  logic        near_lock;
  logic        sync_req;
  logic        both_lock;
  logic        phase_ok;
  logic        sysref_unsynced;
  logic        pll2_lock;

  // ****************************************************************
  // condition derivation
  // ****************************************************************
  alms_cond u_cond (
    .core_clk            (core_clk),
    .rst                 (rst),
    .pll1_lock_cnt       (pll1_lock_cnt),
    .pll1_lock_limit     (pll1_lock_limit),
    .pll1_locked         (pll1_locked),
    .pll2_locked         (pll2_locked),
    .pll2_disabled       (pll2_disabled),
    .dividers_synced     (dividers_synced),
    .ext_sync_pulse      (ext_sync_pulse),
    .spi_sync_req        (spi_sync_req),
    .sysref_phase_stable (sysref_phase_stable),
    .near_lock           (near_lock),
    .sync_req            (sync_req),
    .both_lock           (both_lock),
    .phase_ok            (phase_ok),
    .sysref_unsynced     (sysref_unsynced),
    .pll2_lock           (pll2_lock)
  );

  // ****************************************************************
  // status vectors and alarm
  // ****************************************************************
  always_comb begin
    pll1_status                        = 8'h00;
    pll1_status[`ALMS_P1_NEAR_LOCK]    = near_lock;
    pll1_status[`ALMS_P1_ACQUIRE]      = pll1_acquiring;
    pll1_status[`ALMS_P1_LOCKED]       = pll1_locked;
    pll1_status[`ALMS_P1_HOLDOVER]     = pll1_holdover;
    pll1_status[`ALMS_P1_LOS_HI:0]     = input_signal_lost;
    gen_status                         = 8'h00;
    gen_status[`ALMS_GEN_SYNC_REQ]     = sync_req;
    gen_status[`ALMS_GEN_BOTH_LOCK]    = both_lock;
    gen_status[`ALMS_GEN_PHASE]        = phase_ok;
    gen_status[`ALMS_GEN_SYSREF_SYNC]  = sysref_unsynced;
    gen_status[`ALMS_GEN_PLL2_LOCK]    = pll2_lock;
  end

  // each condition bit gated by the mask bit at the same position
  assign alarm_c =
    |(pll1_status & s_ff.pll1_mask) |
    |(gen_status & s_ff.gen_mask);
  // pll1 mask [3:0] gates input_signal_lost[3:0]
  // general mask [0] gates pll2 lock

  // ****************************************************************
  // register read decode
  // ****************************************************************
  function automatic alms_byte_t reg_read(
    input alms_addr_t addr,
    input alms_byte_t p1_mask,
    input alms_byte_t g_mask,
    input logic       alm,
    input alms_byte_t p1_stat
  );
    alms_byte_t d;
    d = 8'h00;
    unique case (addr)
      `ALMS_ADDR_PLL1_MASK: d = p1_mask;
      `ALMS_ADDR_GEN_MASK:  d = g_mask;
      `ALMS_ADDR_ID_LOW:    d = PRODUCT_ID[7:0];
      `ALMS_ADDR_ID_MID:    d = PRODUCT_ID[15:8];
      `ALMS_ADDR_ID_HIGH:   d = PRODUCT_ID[23:16];
      `ALMS_ADDR_ALARM_RB:  d[`ALMS_RB_ALARM] = alm;
      `ALMS_ADDR_PLL1_STAT: d = p1_stat;
      default:              d = 8'h00;
    endcase
    return d;
  endfunction

  // ****************************************************************
  // serial port and register file
  // ****************************************************************
  assign sclk_rise = spi_sclk & ~s_ff.sclk_q;
  assign sclk_fall = ~spi_sclk & s_ff.sclk_q;
  assign instr     = {s_ff.shift[14:0], sdio_in};
  assign wbyte     = {s_ff.shift[6:0], sdio_in};

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.sclk_q = spi_sclk;
    nxt_s.alarm  = alarm_c;
    if (spi_sen_n) begin
      nxt_s.phase   = ALMS_IDLE;
      nxt_s.bit_cnt = 5'h00;
      nxt_s.sdo_en  = 1'b0;
      nxt_s.sdo     = 1'b0;
    end else begin
      unique case (s_ff.phase)
        ALMS_IDLE: begin
          nxt_s.phase   = ALMS_INSTR;
          nxt_s.bit_cnt = 5'h00;
        end
        ALMS_INSTR: begin
          if (sclk_rise) begin
            nxt_s.shift   = instr;
            nxt_s.bit_cnt = s_ff.bit_cnt + 5'h01;
            if (s_ff.bit_cnt == `ALMS_INSTR_LAST) begin
              nxt_s.bit_cnt = 5'h00;
              nxt_s.addr    = instr[12:0];
              if (instr[15]) begin
                nxt_s.phase  = ALMS_RDATA;
                nxt_s.sdo_en = 1'b1;
                nxt_s.rd_sh  = reg_read(instr[12:0], s_ff.pll1_mask,
                                        s_ff.gen_mask, s_ff.alarm,
                                        pll1_status);
              end else begin
                nxt_s.phase  = ALMS_WDATA;
              end
            end
          end
        end
        ALMS_WDATA: begin
          if (sclk_rise) begin
            nxt_s.shift   = instr;
            nxt_s.bit_cnt = s_ff.bit_cnt + 5'h01;
            if (s_ff.bit_cnt == `ALMS_BYTE_LAST) begin
              nxt_s.bit_cnt = 5'h00;
              nxt_s.addr    = s_ff.addr - 13'h0001;
              // read-only addresses fall through untouched
              if (s_ff.addr == `ALMS_ADDR_PLL1_MASK) begin
                nxt_s.pll1_mask = wbyte;
              end else if (s_ff.addr == `ALMS_ADDR_GEN_MASK) begin
                nxt_s.gen_mask  = wbyte & `ALMS_GEN_USED_MASK;
              end
            end
          end
        end
        ALMS_RDATA: begin
          if (sclk_fall) begin
            nxt_s.sdo   = s_ff.rd_sh[7];
            nxt_s.rd_sh = {s_ff.rd_sh[6:0], 1'b0};
          end
          if (sclk_rise) begin
            nxt_s.bit_cnt = s_ff.bit_cnt + 5'h01;
            if (s_ff.bit_cnt == `ALMS_BYTE_LAST) begin
              nxt_s.bit_cnt = 5'h00;
              nxt_s.addr    = s_ff.addr - 13'h0001;
              nxt_s.rd_sh   = reg_read(s_ff.addr - 13'h0001,
                                       s_ff.pll1_mask, s_ff.gen_mask,
                                       s_ff.alarm, pll1_status);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_ff           <= '0;
      s_ff.pll1_mask <= `ALMS_RST_PLL1_MASK;
      s_ff.gen_mask  <= `ALMS_RST_GEN_MASK;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign sdio_out = s_ff.sdo;
  assign sdio_oe  = s_ff.sdo_en;
  assign alarm    = s_ff.alarm;

endmodule

// ===== alms_top_properties.sv
// port checker of the alarm mask and status block.
// assumes a bind to alms_top; sees only that module's ports.
`timescale 1ns/1ps

module alms_top_properties
  import alms_pkg::*;
(
  // clock and reset
  input logic        core_clk,
  input logic        rst,
  // serial port
  input logic        spi_sclk,
  input logic        spi_sen_n,
  input logic        sdio_out,
  input logic        sdio_oe,
  // status
  input logic [15:0] pll1_lock_cnt,
  input logic [15:0] pll1_lock_limit,
  input logic        pll1_acquiring,
  input logic        pll1_locked,
  input logic        pll1_holdover,
  input logic [3:0]  input_signal_lost,
  input logic        pll2_locked,
  input logic        pll2_disabled,
  input logic        dividers_synced,
  input logic        ext_sync_pulse,
  input logic        spi_sync_req,
  input logic        sysref_phase_stable,
  // alarm
  input logic        alarm
);
  logic        synced_ff;
  logic        sclk_q_ff;
  logic [44:0] in_q_ff;
  logic [44:0] in_w;
  logic        any_cond;
  logic        in_still;
  logic        fall_w;

  assign in_w = {pll1_lock_cnt, pll1_lock_limit, pll1_acquiring, pll1_locked,
                 pll1_holdover, input_signal_lost, pll2_locked, pll2_disabled,
                 dividers_synced, ext_sync_pulse, spi_sync_req,
                 sysref_phase_stable};
  assign in_still = (in_w == in_q_ff);
  assign fall_w   = sclk_q_ff & ~spi_sclk;
  // true when some mask could pass a condition on to the alarm
  assign any_cond = (pll1_lock_cnt >= (pll1_lock_limit >> 4))
                  | pll1_acquiring | pll1_locked | pll1_holdover
                  | (|input_signal_lost) | pll2_locked | pll2_disabled
                  | sysref_phase_stable | ~synced_ff;

  always_ff @(posedge core_clk) begin
    sclk_q_ff <= spi_sclk;
    in_q_ff   <= in_w;
    if (rst)
      synced_ff <= 1'b0;
    else if (ext_sync_pulse | spi_sync_req)
      synced_ff <= 1'b1;
  end

  // ********
  // properties
  // ********
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_release_alarm_low: assert property ($fell(rst) |-> !alarm [*8])
    else $error("alarm high right after reset");
  a_release_port_idle: assert property (
    $fell(rst) |-> !sdio_oe && !sdio_out)
    else $error("serial output active right after reset");
  a_quiet_no_alarm: assert property ((!any_cond) [*3] |=> !alarm)
    else $error("alarm high with no condition active");
  a_alarm_has_cause: assert property (
    alarm |-> $past(any_cond) || $past(any_cond, 2))
    else $error("alarm high without a recent condition");
  a_steady_alarm: assert property (
    (spi_sen_n && in_still) [*3] |=> $stable(alarm))
    else $error("alarm moved with inputs and port idle");
  a_oe_idle_low: assert property (spi_sen_n |=> !sdio_oe)
    else $error("sdio driven outside a frame");
  a_oe_after_rise: assert property (
    $rose(sdio_oe) |-> $past(!spi_sen_n) && $past(spi_sclk))
    else $error("sdio drive began without a clock rise");
  a_out_on_fall: assert property (
    $changed(sdio_out) && sdio_oe && $past(sdio_oe) |-> $past(fall_w))
    else $error("read bit changed without a clock fall");

  c_alarm_rise: cover property ($rose(alarm));
  c_read_frame: cover property ($rose(sdio_oe));
  c_sync_event: cover property ($rose(synced_ff));
endmodule

// ===== testbench.sv
// self-checking bench of the alarm mask and status block.
// assumes the serial port and all status inputs are driven here.
`timescale 1ns/1ps
`include "alms_regs.svh"

module testbench
  import alms_pkg::*;
;
  // arbitrary identifier value
  localparam logic [23:0] ID = 24'hc3a512;

  logic        core_clk, rst, spi_sclk, spi_sen_n, tb_sdio, sdio_in;
  logic        sdio_out, sdio_oe, alarm, pll1_acquiring, pll1_locked;
  logic        pll1_holdover, pll2_locked, pll2_disabled, dividers_synced;
  logic        ext_sync_pulse, spi_sync_req, sysref_phase_stable;
  logic        prev_sclk, synced, ea;
  logic [15:0] pll1_lock_cnt, pll1_lock_limit;
  logic [3:0]  input_signal_lost;
  logic [12:0] cond, m;
  alms_byte_t  exp_q[$];
  alms_byte_t  rd_sh;
  int          failures = 0;
  int          cmp_count = 0;
  int          nbit = 0;
  int          seed = 32'h7d61;

  assign sdio_in = sdio_oe ? sdio_out : tb_sdio;

  alms_top #(.PRODUCT_ID(ID)) dut (
    .core_clk, .rst, .spi_sclk, .spi_sen_n, .sdio_in, .sdio_out, .sdio_oe,
    .pll1_lock_cnt, .pll1_lock_limit, .pll1_acquiring, .pll1_locked,
    .pll1_holdover, .input_signal_lost, .pll2_locked, .pll2_disabled,
    .dividers_synced, .ext_sync_pulse, .spi_sync_req, .sysref_phase_stable,
    .alarm
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ********
  // tasks
  // ********
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(string nm, alms_byte_t e, alms_byte_t g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_alarm(logic e);
    cyc(4);
    chk("alarm", {7'h00, e}, {7'h00, alarm});
  endtask

  // one frame: instruction then nb data bytes, each level two cycles
  task automatic xfer(logic r, alms_addr_t a, alms_byte_t d, int nb);
    logic [15:0] ins;
    ins = {r, 2'b00, a};
    spi_sen_n = 1'b0;
    cyc(1);
    for (int i = 8 * nb + 15; i >= 0; i--) begin
      tb_sdio = (i >= 8 * nb) ? ins[i - 8 * nb] : d[i % 8];
      cyc(2);
      spi_sclk = 1'b1;
      cyc(2);
      spi_sclk = 1'b0;
    end
    spi_sen_n = 1'b1;
    cyc(2);
  endtask

  task automatic wr(alms_addr_t a, alms_byte_t d);
    xfer(1'b0, a, d, 1);
  endtask

  task automatic rd(alms_addr_t a, alms_byte_t e);
    exp_q.push_back(e);
    xfer(1'b1, a, 8'h00, 1);
  endtask

  task automatic stim();
    logic [31:0] r;
    r = $random(seed);
    pll1_lock_limit = r[31:16];
    pll1_lock_cnt = (r[31:16] >> 4) - {15'h0000, r[0]};
    {pll1_acquiring, pll1_locked, pll1_holdover} = r[3:1];
    input_signal_lost = r[7:4];
    {pll2_locked, pll2_disabled, dividers_synced} = r[10:8];
    sysref_phase_stable = r[11];
    cond[7] = pll1_lock_cnt >= (pll1_lock_limit >> 4);
    cond[6:0] = {r[3:1], r[7:4]};
    cond[12:8] = {(pll2_locked | pll2_disabled) & ~dividers_synced,
                  pll1_locked & pll2_locked, r[11], ~synced, pll2_locked};
  endtask

  task automatic end_sim();
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // read bits are taken at each clock rise while the block drives sdio
  always @(posedge core_clk) begin
    prev_sclk <= spi_sclk;
    if (!sdio_oe)
      nbit = 0;
    else if (spi_sclk && !prev_sclk) begin
      rd_sh = {rd_sh[6:0], sdio_out};
      nbit++;
      if (nbit == 8) begin
        nbit = 0;
        if (exp_q.size() > 0)
          chk("read", exp_q.pop_front(), rd_sh);
        else begin
          failures++;
          $display("[ERR] read expected none seen %h", rd_sh);
        end
      end
    end
  end

  // ********
  // sequence
  // ********
  initial begin
    {rst, spi_sclk, spi_sen_n, tb_sdio} = 4'b1010;
    {pll1_lock_cnt, pll1_lock_limit} = 32'h0000ffff;
    {pll1_acquiring, pll1_locked, pll1_holdover} = 3'b000;
    input_signal_lost = 4'h0;
    {pll2_locked, pll2_disabled, dividers_synced} = 3'b001;
    {ext_sync_pulse, spi_sync_req, sysref_phase_stable} = 3'b000;
    for (int j = 0; j < 2; j++) begin
      rst = 1'b1;
      cyc(4);
      rst = 1'b0;
      synced = 1'b0;
      rd(`ALMS_ADDR_GEN_MASK, `ALMS_RST_GEN_MASK);
      wr(`ALMS_ADDR_GEN_MASK, 8'h02);
      chk_alarm(1'b1);
      if (j == 0)
        ext_sync_pulse = 1'b1;
      else
        spi_sync_req = 1'b1;
      cyc(1);
      {ext_sync_pulse, spi_sync_req} = 2'b00;
      synced = 1'b1;
      chk_alarm(1'b0);
    end
    wr(`ALMS_ADDR_PLL1_MASK, 8'h5a);
    rd(`ALMS_ADDR_PLL1_MASK, 8'h5a);
    wr(`ALMS_ADDR_GEN_MASK, 8'hff);
    rd(`ALMS_ADDR_GEN_MASK, `ALMS_GEN_USED_MASK);
    rd(13'h0072, 8'h00);
    // descending streams: two mask bytes written, three id bytes read
    xfer(1'b0, `ALMS_ADDR_GEN_MASK, 8'h3c, 2);
    rd(`ALMS_ADDR_GEN_MASK, 8'h1c);
    rd(`ALMS_ADDR_PLL1_MASK, 8'h3c);
    for (int i = 2; i >= 0; i--)
      exp_q.push_back(ID[8*i +: 8]);
    xfer(1'b1, `ALMS_ADDR_ID_HIGH, 8'h00, 3);
    for (int i = 0; i < 3; i++) begin
      wr(`ALMS_ADDR_ID_LOW + 13'(i), 8'hff);
      rd(`ALMS_ADDR_ID_LOW + 13'(i), ID[8*i +: 8]);
    end
    wr(`ALMS_ADDR_ALARM_RB, 8'hff);
    wr(`ALMS_ADDR_PLL1_STAT, 8'hff);
    for (int k = 0; k < 39; k++) begin
      m = 13'h0001 << (k % 13);
      wr(`ALMS_ADDR_PLL1_MASK, m[7:0]);
      wr(`ALMS_ADDR_GEN_MASK, {3'h0, m[12:8]});
      stim();
      ea = |(cond & m);
      chk_alarm(ea);
      rd(`ALMS_ADDR_ALARM_RB, {7'h00, ea});
      rd(`ALMS_ADDR_PLL1_STAT, cond[7:0]);
    end
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    $display("[ERR] watchdog expected done seen timeout");
    end_sim();
  end
endmodule

bind alms_top alms_top_properties chk (
  .core_clk, .rst, .spi_sclk, .spi_sen_n, .sdio_out, .sdio_oe,
  .pll1_lock_cnt, .pll1_lock_limit, .pll1_acquiring, .pll1_locked,
  .pll1_holdover, .input_signal_lost, .pll2_locked, .pll2_disabled,
  .dividers_synced, .ext_sync_pulse, .spi_sync_req, .sysref_phase_stable,
  .alarm
);
